// >>> hdl/nwsl_near_cmp.sv
// near-position comparator
// assumes pos_error is sampled every control cycle, two's complement
`timescale 1ns/1ps
module nwsl_near_cmp (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [31:0] pos_error,
  input wire logic [31:0] width,
  output logic near
);
  import nwsl_pkg::*;

  // flag set while |error| is below the window width
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      near <= 1'b0;
    end else if (ce) begin
      near <= (mag32(pos_error) < width);
    end
  end
endmodule

// >>> hdl/nwsl_pkg.sv
// package: constants, register map and carrier types for the near window / speed limit block
// assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock
package nwsl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_NEAR_WIDTH = 8'h04;
  localparam logic [7:0] OFF_SPEED_CAP = 8'h08;
  localparam logic [7:0] OFF_MOTOR_MAX = 8'h0c;
  localparam logic [7:0] OFF_OVERSPEED = 8'h10;
  localparam logic [7:0] OFF_EXT_CAP = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_ACTIVE_LIM = 8'h24;
  // control register field positions
  localparam int CTRL_LIMIT_SRC_BIT = 0;
  localparam int CTRL_CEIL_SEL_BIT = 1;
  localparam int CTRL_NEAR_PIN_BIT = 2;
  localparam int CTRL_LIM_PIN_BIT = 3;
  localparam int CTRL_FORCE_MODE_BIT = 4;
  localparam int CTRL_RESTART_BIT = 5;
  // reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] NEAR_WIDTH_RESET = 32'h4000_0000; // 1073741824
  localparam logic [31:0] NEAR_WIDTH_MIN = 32'h0000_0001;
  localparam logic [15:0] SPEED_CAP_RESET = 16'h2710; // 10000 mm/s
  localparam logic [15:0] SPEED_CAP_MAX = 16'h2710;
  localparam logic [15:0] MOTOR_MAX_RESET = 16'h1388;
  localparam logic [15:0] OVERSPEED_RESET = 16'h157c;
  localparam logic [15:0] EXT_CAP_RESET = 16'h0000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // interrupt status bit positions
  localparam int IRQ_NEAR_BIT = 0;
  localparam int IRQ_LIM_BIT = 1;
  // bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // settings latched on restart
  typedef struct packed {
    logic limit_source_select;
    logic cap_ceiling_select;
  } restart_cfg_t;

  // live control-loop samples
  typedef struct packed {
    logic [31:0] pos_error;
    logic [15:0] speed;
  } loop_sample_t;

  // flag pair
  typedef struct packed {
    logic speed_limited_flag;
    logic near_flag;
  } flags_t;

  // smaller of two unsigned speeds
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  // magnitude of a two's complement value
  function automatic logic [31:0] mag32(input logic [31:0] v);
    mag32 = v[31] ? (~v + 32'h0000_0001) : v;
  endfunction
endpackage

// >>> hdl/nwsl_speed_lim.sv
// speed clamp for force control
// assumes speed is a signed 16-bit sample per control cycle
`timescale 1ns/1ps
module nwsl_speed_lim (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic force_mode,
  input wire logic [15:0] speed,
  input wire logic [15:0] limit,
  output logic [15:0] speed_out,
  output logic limited
);
  import nwsl_pkg::*;
  logic [15:0] mag;

  assign mag = speed[15] ? (~speed + 16'h0001) : speed;

  // clamp magnitude, keep sign; flag only while clamp applies
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      speed_out <= 16'h0000;
      limited <= 1'b0;
    end else if (ce) begin
      if (force_mode && mag >= limit) begin
        speed_out <= speed[15] ? (~limit + 16'h0001) : limit;
        limited <= 1'b1;
      end else begin
        speed_out <= speed;
        limited <= 1'b0;
      end
    end
  end
endmodule

// >>> hdl/nwsl_top.sv
// top: near window flag and force-control speed limit with AXI4-Lite registers
// assumes one synchronous clock, inputs synchronous to SYS_CLK
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module nwsl_top (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire nwsl_pkg::loop_sample_t LOOP_IN,
  output logic [15:0] SPEED_LIMITED_OUT,
  output logic NEAR_PIN,
  output logic LIMITED_PIN,
  output logic IRQ,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import nwsl_pkg::*;

  logic [31:0] ctrl_q;
  logic [31:0] near_width_q;
  logic [15:0] speed_cap_q;
  logic [15:0] motor_max_q;
  logic [15:0] overspeed_q;
  logic [15:0] ext_cap_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  restart_cfg_t cfg_q;
  flags_t flags;
  flags_t flags_prev_q;
  logic [15:0] ceiling;
  logic [15:0] int_limit;
  logic [15:0] active_limit_q;
  logic [7:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic do_write;
  logic wr_ok;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [1:0] irq_rise;
  logic [1:0] irq_w1c;
  logic [31:0] near_wr;
  logic [31:0] cap_wr;
  logic [31:0] motor_wr;
  logic [31:0] over_wr;
  logic [31:0] ext_wr;
  logic restart;
  logic wr_idle;

  // byte-lane merge for 32-bit writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // write channel capture: address and data in either order
  // readies drop while the enable is low, since nothing would be taken then
  assign wr_idle = CE && !S_AXI_BVALID;
  assign S_AXI_AWREADY = !aw_held_q && wr_idle;
  assign S_AXI_WREADY = !w_held_q && wr_idle;
  assign do_write = aw_held_q && w_held_q && !S_AXI_BVALID;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write decode validity
  always_comb begin
    case (awaddr_q)
      OFF_CTRL, OFF_NEAR_WIDTH, OFF_SPEED_CAP, OFF_MOTOR_MAX, OFF_OVERSPEED,
      OFF_EXT_CAP, OFF_IRQ_STAT, OFF_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (CE) begin
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // write data merged onto each register's current value, 32 bits wide
  always_comb begin
    near_wr = merge(near_width_q, wdata_q, wstrb_q);
    cap_wr = merge({16'h0000, speed_cap_q}, wdata_q, wstrb_q);
    motor_wr = merge({16'h0000, motor_max_q}, wdata_q, wstrb_q);
    over_wr = merge({16'h0000, overspeed_q}, wdata_q, wstrb_q);
    ext_wr = merge({16'h0000, ext_cap_q}, wdata_q, wstrb_q);
  end

  // configuration registers
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= CTRL_RESET;
      near_width_q <= NEAR_WIDTH_RESET;
      speed_cap_q <= SPEED_CAP_RESET;
      motor_max_q <= MOTOR_MAX_RESET;
      overspeed_q <= OVERSPEED_RESET;
      ext_cap_q <= EXT_CAP_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (CE) begin
      ctrl_q[CTRL_RESTART_BIT] <= 1'b0; // restart is a self-clearing strobe
      if (do_write) begin
        case (awaddr_q)
          OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_003f;
          OFF_NEAR_WIDTH: begin
            // width below the minimum is held at the minimum
            if (near_wr < NEAR_WIDTH_MIN) begin
              near_width_q <= NEAR_WIDTH_MIN;
            end else begin
              near_width_q <= near_wr;
            end
          end
          OFF_SPEED_CAP: begin
            // cap range is 0..10000, effective at once
            if (cap_wr > {16'h0000, SPEED_CAP_MAX}) begin
              speed_cap_q <= SPEED_CAP_MAX;
            end else begin
              speed_cap_q <= cap_wr[15:0];
            end
          end
          OFF_MOTOR_MAX: motor_max_q <= motor_wr[15:0];
          OFF_OVERSPEED: overspeed_q <= over_wr[15:0];
          OFF_EXT_CAP: ext_cap_q <= ext_wr[15:0];
          OFF_IRQ_MASK: irq_mask_q <= wdata_q[1:0];
          default: ;
        endcase
      end
    end
  end

  // restart strobe, high for one enabled cycle after the control write
  assign restart = ctrl_q[CTRL_RESTART_BIT];

  // select fields take effect only on a restart strobe
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_q <= '0;
    end else if (CE && restart) begin
      cfg_q.limit_source_select <= ctrl_q[CTRL_LIMIT_SRC_BIT];
      cfg_q.cap_ceiling_select <= ctrl_q[CTRL_CEIL_SEL_BIT];
    end
  end

  // internal cap bounded by the chosen ceiling
  assign ceiling = cfg_q.cap_ceiling_select ? overspeed_q : motor_max_q;
  assign int_limit = min16(ceiling, speed_cap_q);

  // active limit per control cycle
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      active_limit_q <= SPEED_CAP_RESET;
    end else if (CE) begin
      active_limit_q <= cfg_q.limit_source_select ? ext_cap_q : int_limit;
    end
  end

  nwsl_near_cmp i_nwsl_near_cmp (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .pos_error(LOOP_IN.pos_error),
    .width(near_width_q),
    .near(flags.near_flag)
  );

  nwsl_speed_lim i_nwsl_speed_lim (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .force_mode(ctrl_q[CTRL_FORCE_MODE_BIT]),
    .speed(LOOP_IN.speed),
    .limit(active_limit_q),
    .speed_out(SPEED_LIMITED_OUT),
    .limited(flags.speed_limited_flag)
  );

  // output lines gated by pin assignment
  assign NEAR_PIN = flags.near_flag & ctrl_q[CTRL_NEAR_PIN_BIT];
  assign LIMITED_PIN = flags.speed_limited_flag & ctrl_q[CTRL_LIM_PIN_BIT];

  // sticky interrupt bits on rising flags; set wins over clear
  assign irq_rise = {flags.speed_limited_flag & ~flags_prev_q.speed_limited_flag,
                     flags.near_flag & ~flags_prev_q.near_flag};
  assign irq_w1c = (do_write && awaddr_q == OFF_IRQ_STAT && wstrb_q[0]) ? wdata_q[1:0] : 2'h0;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_prev_q <= '0;
      irq_stat_q <= 2'h0;
    end else if (CE) begin
      flags_prev_q <= flags;
      irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_rise;
    end
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // read decode
  always_comb begin
    rd_ok = 1'b1;
    case (S_AXI_ARADDR)
      OFF_CTRL: rd_val = ctrl_q;
      OFF_NEAR_WIDTH: rd_val = near_width_q;
      OFF_SPEED_CAP: rd_val = {16'h0000, speed_cap_q};
      OFF_MOTOR_MAX: rd_val = {16'h0000, motor_max_q};
      OFF_OVERSPEED: rd_val = {16'h0000, overspeed_q};
      OFF_EXT_CAP: rd_val = {16'h0000, ext_cap_q};
      OFF_STATUS: rd_val = {28'h0000000, cfg_q, flags};
      OFF_IRQ_STAT: rd_val = {30'h0, irq_stat_q};
      OFF_IRQ_MASK: rd_val = {30'h0, irq_mask_q};
      OFF_ACTIVE_LIM: rd_val = {16'h0000, active_limit_q};
      default: begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // read channel
  // address ready also waits for the enable, so no request is lost while frozen
  assign S_AXI_ARREADY = CE && !S_AXI_RVALID;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// >>> verif/nwsl_host_model.sv
// host model: supplies host-side settings and counts near interlock events
// assumes the bench programs the drive with the values offered here
`timescale 1ns/1ps
module nwsl_host_model #(
  parameter logic [31:0] COMPLETE_W = 32'h0000_0007,
  parameter logic [31:0] NEAR_W = 32'h0000_000a,
  parameter logic [15:0] EXT_CAP = 16'h04d2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic near_in,
  output logic [31:0] near_width,
  output logic [15:0] ext_cap,
  output logic [7:0] near_rises
);
  logic near_q;
  logic [7:0] rises_q;
  // near window kept wider than the completion window
  assign near_width = (NEAR_W > COMPLETE_W) ? NEAR_W : COMPLETE_W + 32'h1;
  assign ext_cap = EXT_CAP;
  assign near_rises = rises_q;
  // count rising edges of the near line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      near_q <= 1'b0;
      rises_q <= 8'h00;
    end else begin
      near_q <= near_in;
      if (near_in && !near_q) rises_q <= rises_q + 8'h01;
    end
  end
endmodule

// >>> verif/nwsl_top_props.sv
// checker: bus handshakes and clamp relations at the top ports
// assumes one clock domain and is bound onto every nwsl_top
`timescale 1ns/1ps
module nwsl_top_props (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire nwsl_pkg::loop_sample_t LOOP_IN,
  input wire logic [15:0] SPEED_LIMITED_OUT,
  input wire logic NEAR_PIN,
  input wire logic LIMITED_PIN,
  input wire logic IRQ,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import nwsl_pkg::*;
  logic [15:0] in_mag;
  logic [15:0] out_mag;
  logic in_neg;
  // magnitudes and sign of the speed before and after the clamp
  assign in_mag = LOOP_IN.speed[15] ? -LOOP_IN.speed : LOOP_IN.speed;
  assign out_mag = SPEED_LIMITED_OUT[15] ? -SPEED_LIMITED_OUT : SPEED_LIMITED_OUT;
  assign in_neg = LOOP_IN.speed[15];
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  a_clamp_bound: assert property (CE |=> out_mag <= $past(in_mag))
    else $error("clamped speed larger than input");
  a_sign_kept: assert property (CE && in_mag != 16'h0 |=> out_mag == 16'h0 || SPEED_LIMITED_OUT[15] == $past(in_neg))
    else $error("clamp changed speed sign");
  a_ce_freeze: assert property (!CE |=> $stable(SPEED_LIMITED_OUT) && $stable(IRQ) && $stable(NEAR_PIN))
    else $error("outputs moved while enable low");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && CE
    |-> ##[1:3] S_AXI_BVALID) else $error("write response missing");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY && CE |=> S_AXI_RVALID)
    else $error("read data late");
  a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped or changed");
  a_aw_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("address taken while response pending");
  a_unmapped_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
    else $error("error read carries data");
  c_near: cover property (NEAR_PIN);
  c_limited: cover property (LIMITED_PIN);
  c_irq: cover property (IRQ);
  c_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
endmodule

bind nwsl_top nwsl_top_props i_nwsl_top_props (.SYS_CLK, .ARST_N, .CE, .LOOP_IN, .SPEED_LIMITED_OUT,
  .NEAR_PIN, .LIMITED_PIN, .IRQ, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
  .S_AXI_RVALID, .S_AXI_RREADY);

// >>> verif/tb_nwsl_top.sv
// bench: register, near window, speed clamp and interrupt sequences
// assumes the checker binds itself and the host model watches the near line
`timescale 1ns/1ps
module tb_nwsl_top;
  import nwsl_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  loop_sample_t loop_in = '{pos_error: 32'h7fff_ffff, speed: 16'h0};
  logic [15:0] spd, xcap;
  logic near_pin, lim_pin, irq, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, nw;
  logic [7:0] rises;
  logic [31:0] rst_tbl [10] = '{32'h0, 32'h4000_0000, 32'h2710, 32'h1388, 32'h157c, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h1388};
  logic [31:0] err_tbl [4] = '{32'h5, 32'ha, 32'hffff_fff7, 32'hffff_fff6};
  logic [3:0] near_exp = 4'b0101;
  int n_mismatch = 0;
  int checked = 0;

  nwsl_top i_nwsl_top (.SYS_CLK(clk), .ARST_N(arst_n), .CE(ce), .LOOP_IN(loop_in), .SPEED_LIMITED_OUT(spd),
    .NEAR_PIN(near_pin), .LIMITED_PIN(lim_pin), .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  nwsl_host_model i_nwsl_host_model (.clk(clk), .arst_n(arst_n), .near_in(near_pin), .near_width(nw),
    .ext_cap(xcap), .near_rises(rises));

  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [31:0] ev, input logic [31:0] got);
    checked++;
    if (got !== ev) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, ev, got);
    end
  endtask

  // bus write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    bit ap, wp;
    int t;
    logic [1:0] r;
    ap = 1;
    wp = 1;
    t = 0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    while (r === 2'h3 && t < 50) begin
      @(posedge clk);
      t++;
      if (ap && awrdy) awv <= 1'b0;
      if (wp && wrdy) wv <= 1'b0;
      ap = ap && !awrdy;
      wp = wp && !wrdy;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
      end
    end
    cmp("bresp", {30'h0, er}, {30'h0, r});
  endtask

  // bus read with data and response comparison
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    bit ap;
    int t;
    logic [1:0] r;
    logic [31:0] v;
    ap = 1;
    t = 0;
    r = 2'h3;
    v = 32'h0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    while (r === 2'h3 && t < 50) begin
      @(posedge clk);
      t++;
      if (ap && arrdy) arv <= 1'b0;
      ap = ap && !arrdy;
      if (rvalid) begin
        v = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    cmp(what, ev, v);
    cmp("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // hold one loop sample until flags and clamp have settled
  task automatic smp(input logic [31:0] e, input logic [15:0] s);
    @(posedge clk);
    loop_in <= '{pos_error: e, speed: s};
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic lim(input logic [15:0] s, input logic [15:0] eo, input logic el);
    smp(32'h7fff_ffff, s);
    cmp("speed", {16'h0, eo}, {16'h0, spd});
    cmp("limited", {31'h0, el}, {31'h0, lim_pin});
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #2000000;
    n_mismatch++;
    test_done;
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rdc("reset value", 8'(4 * i), rst_tbl[i], RESP_OKAY);
    rdc("unmapped", 8'h28, 32'h0, RESP_SLVERR);
    wr(OFF_STATUS, 32'h3, RESP_SLVERR);
    wr(OFF_NEAR_WIDTH, nw, RESP_OKAY);
    smp(32'h5, 16'h0);
    cmp("near unassigned", 32'h0, {31'h0, near_pin});
    wr(OFF_CTRL, 32'h04, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      smp(err_tbl[i], 16'h0);
      cmp("near", {31'h0, near_exp[i]}, {31'h0, near_pin});
    end
    cmp("host near rises", 32'h2, {24'h0, rises});
    wr(OFF_CTRL, 32'h1c, RESP_OKAY);
    lim(16'h1770, 16'h1388, 1'b1);
    lim(16'he890, 16'hec78, 1'b1);
    lim(16'h1388, 16'h1388, 1'b1);
    lim(16'h0064, 16'h0064, 1'b0);
    wr(OFF_CTRL, 32'h14, RESP_OKAY);
    lim(16'h1770, 16'h1388, 1'b0);
    wr(OFF_CTRL, 32'h1c, RESP_OKAY);
    wr(OFF_SPEED_CAP, 32'h0bb8, RESP_OKAY);
    lim(16'h0fa0, 16'h0bb8, 1'b1);
    wr(OFF_SPEED_CAP, 32'h4e20, RESP_OKAY);
    rdc("cap", OFF_SPEED_CAP, 32'h2710, RESP_OKAY);
    wr(OFF_CTRL, 32'h1e, RESP_OKAY);
    lim(16'h1770, 16'h1388, 1'b1);
    wr(OFF_CTRL, 32'h3e, RESP_OKAY);
    lim(16'h1770, 16'h157c, 1'b1);
    wr(OFF_EXT_CAP, {16'h0, xcap}, RESP_OKAY);
    lim(16'h1770, 16'h157c, 1'b1);
    wr(OFF_CTRL, 32'h3f, RESP_OKAY);
    lim(16'h07d0, xcap, 1'b1);
    rdc("status", OFF_STATUS, 32'he, RESP_OKAY);
    rdc("active limit", OFF_ACTIVE_LIM, {16'h0, xcap}, RESP_OKAY);
    wr(OFF_CTRL, 32'h0c, RESP_OKAY);
    lim(16'h1770, 16'h1770, 1'b0);
    // interrupts: latched, masked, level output, write-one clear
    cmp("irq masked", 32'h0, {31'h0, irq});
    rdc("irq status", OFF_IRQ_STAT, 32'h3, RESP_OKAY);
    wr(OFF_IRQ_MASK, 32'h2, RESP_OKAY);
    @(negedge clk);
    cmp("irq", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
    @(negedge clk);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    rdc("irq status", OFF_IRQ_STAT, 32'h1, RESP_OKAY);
    // enable low freezes the clamp output
    @(posedge clk);
    ce <= 1'b0;
    smp(32'h7fff_ffff, 16'h0100);
    cmp("frozen speed", 32'h1770, {16'h0, spd});
    @(posedge clk);
    ce <= 1'b1;
    test_done;
  end
endmodule
